// ===== bench/rpwf_host.sv
`timescale 1ns/1ns
`default_nettype none
module rpwf_host (
    output logic csn,
    output logic sck,
    output logic mosi,
    input wire logic miso
);
    logic [7:0] tx_b [0:35];
    logic [7:0] rx_b [0:35];
    initial begin
        csn = 1'b1;
        sck = 1'b0;
        mosi = 1'b0;
    end
    // ****************************************************************
    // mode 0 frame, 125 ns link clock, idle low outside frames
    // ****************************************************************
    task automatic xfer(input int n);
        csn = 1'b0;
        #125;
        for (int i = 0; i < n; i++) begin
            for (int b = 7; b >= 0; b--) begin
                mosi = tx_b[i][b];
                #62;
                sck = 1'b1;
                rx_b[i][b] = miso;
                #63;
                sck = 1'b0;
            end
        end
        #62;
        // released line must not look like held data
        mosi = ~mosi;
        csn = 1'b1;
        #125;
    endtask
endmodule // rpwf_host
`default_nettype wire

// ===== bench/rpwf_top_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module rpwf_top_monitor (
    input wire logic REF_CLK,
    input wire logic RESETN,
    input wire logic CSN,
    input wire logic CE,
    input wire logic TRANSMITTER_ROLE,
    input wire logic GLOBAL_VARIABLE_LENGTH,
    input wire logic [2:0] PIPE_AUTO_ACK,
    input wire rpwf_pkg::rpwf_widths_t PIPE_WIDTHS,
    input wire logic [2:0] PIPE_VARIABLE_LENGTH,
    input wire logic TX_HEAD_VALID,
    input wire logic TX_POP,
    input wire logic TX_RESEND,
    input wire logic RX_PUSH,
    input wire logic RX_PUSH_READY,
    input wire logic [2:0] ACK_PIPE_SEL,
    input wire logic ACK_HEAD_VALID,
    input wire logic ACK_POP
);
    localparam int CE_LO = rpwf_pkg::CE_MIN_CYC;
    localparam int CE_HI = rpwf_pkg::CE_MIN_CYC + 8;
    logic [4:0] csn_hi_q;
    logic [10:0] ce_hi_q;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);
    // ****************************************************************
    // idle and chip-enable counters
    // ****************************************************************
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN || !CSN) begin
            csn_hi_q <= 5'h00;
        end else if (csn_hi_q != 5'h1f) begin
            csn_hi_q <= csn_hi_q + 5'h01;
        end
    end
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN || !CE) begin
            ce_hi_q <= 11'h000;
        end else if (ce_hi_q != 11'h7ff) begin
            ce_hi_q <= ce_hi_q + 11'h001;
        end
    end
    a_width_in_frame: assert property ($changed(PIPE_WIDTHS) |->
        csn_hi_q < 5'h04) else $error("width changed outside a frame");
    a_varlen_gated: assert property (PIPE_VARIABLE_LENGTH ==
        (PIPE_VARIABLE_LENGTH & PIPE_AUTO_ACK)) else $error("varlen ack");
    a_global_gate: assert property (!GLOBAL_VARIABLE_LENGTH |->
        PIPE_VARIABLE_LENGTH == 3'h0) else $error("varlen without global");
    a_resend_window: assert property (TX_RESEND |-> TRANSMITTER_ROLE &&
        TX_HEAD_VALID && ce_hi_q >= CE_LO && ce_hi_q <= CE_HI)
        else $error("resend at wrong time");
    a_resend_single: assert property (TX_RESEND |=> !TX_RESEND [*8])
        else $error("resend repeated");
    a_tx_idle_hold: assert property (csn_hi_q >= 5'h0c &&
        !$past(TX_POP) |-> $stable(TX_HEAD_VALID))
        else $error("tx occupancy changed without cause");
    a_rx_idle_hold: assert property (csn_hi_q >= 5'h0c &&
        !$past(RX_PUSH) |-> $stable(RX_PUSH_READY))
        else $error("rx occupancy changed without cause");
    a_rx_full_refuse: assert property (RX_PUSH && !RX_PUSH_READY &&
        csn_hi_q >= 5'h0c |=> !RX_PUSH_READY) else $error("full rx took");
    a_ack_idle_hold: assert property (csn_hi_q >= 5'h0c &&
        !$past(ACK_POP) && !$past(ACK_POP, 2) &&
        $past(ACK_PIPE_SEL) == $past(ACK_PIPE_SEL, 2) |->
        $stable(ACK_HEAD_VALID)) else $error("ack head changed");
    c_resend: cover property (TX_RESEND);
    c_rx_full_push: cover property (RX_PUSH && !RX_PUSH_READY);
    c_ack_pop: cover property (ACK_POP && ACK_HEAD_VALID);
endmodule // rpwf_top_monitor
`default_nettype wire

// ===== bench/test_rpwf_top.sv
`timescale 1ns/1ns
`default_nettype none
module test_rpwf_top;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic ce = 1'b0;
    logic tx_role = 1'b1;
    logic global_vl = 1'b0;
    logic [2:0] auto_ack = 3'h5;
    logic tx_pop = 1'b0;
    logic rx_push = 1'b0;
    rpwf_pkg::rpwf_entry_t rx_entry = '0;
    logic [2:0] ack_sel = 3'h0;
    logic ack_pop = 1'b0;
    logic csn, sck, mosi, miso, tx_valid, tx_resend, rx_ready, ack_valid;
    logic miso_oe;
    logic [2:0] varlen;
    rpwf_pkg::rpwf_widths_t widths;
    rpwf_pkg::rpwf_entry_t tx_head, ack_head;
    int bad_count = 0;
    int num_checks = 0;
    int resend_n = 0;
    logic [4:0] adr [0:6] = '{5'h12, 5'h13, 5'h14, 5'h15, 5'h16, 5'h1c,
        5'h17};
    logic [7:0] wv [0:5] = '{8'h01, 8'h20, 8'h25, 8'h1f, 8'h00, 8'h38};
    logic [2:0] ap [0:3] = '{3'h2, 3'h2, 3'h4, 3'h2};
    rpwf_host host (.csn(csn), .sck(sck), .mosi(mosi), .miso(miso));
    rpwf_top dut (.REF_CLK(ref_clk), .RESETN(resetn), .CSN(csn), .SCK(sck),
        .MOSI(mosi), .MISO(miso), .MISO_OE(miso_oe), .CE(ce),
        .TRANSMITTER_ROLE(tx_role), .GLOBAL_VARIABLE_LENGTH(global_vl),
        .PIPE_AUTO_ACK(auto_ack), .PIPE_WIDTHS(widths),
        .PIPE_VARIABLE_LENGTH(varlen), .TX_HEAD(tx_head),
        .TX_HEAD_VALID(tx_valid), .TX_POP(tx_pop), .TX_RESEND(tx_resend),
        .RX_PUSH(rx_push), .RX_PUSH_ENTRY(rx_entry),
        .RX_PUSH_READY(rx_ready), .ACK_PIPE_SEL(ack_sel),
        .ACK_HEAD(ack_head), .ACK_HEAD_VALID(ack_valid), .ACK_POP(ack_pop));
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (tx_resend === 1'b1) resend_n <= resend_n + 1;
    end
    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic complete_run();
        if (bad_count == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [264:0] e,
        input logic [264:0] g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic frame(input logic [7:0] cmd, input int n,
        input logic [7:0] s);
        host.tx_b[0] = cmd;
        for (int k = 0; k < n; k++) host.tx_b[k + 1] = s + 8'(k);
        host.xfer(n + 1);
    endtask
    task automatic chk_reg(input logic [4:0] a, input logic [7:0] e);
        frame({rpwf_pkg::CMD_RD_REG, a}, 1, 8'h00);
        chk("register", e, host.rx_b[1]);
    endtask
    task automatic push(input logic [2:0] p, input logic [7:0] v);
        rpwf_pkg::rpwf_entry_t e;
        e.pipe = p;
        e.len = 6'h04;
        for (int k = 0; k < 32; k++) e.data[8 * k +: 8] = v + 8'(k);
        @(posedge ref_clk);
        rx_push <= 1'b1;
        rx_entry <= e;
        @(posedge ref_clk);
        rx_push <= 1'b0;
    endtask
    task automatic pop(input logic tx);
        @(posedge ref_clk);
        tx_pop <= tx;
        ack_pop <= ~tx;
        @(posedge ref_clk);
        tx_pop <= 1'b0;
        ack_pop <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask
    task automatic sel(input logic [2:0] p);
        @(posedge ref_clk);
        ack_sel <= p;
        repeat (3) @(posedge ref_clk);
    endtask
    initial begin
        repeat (60000) @(posedge ref_clk);
        bad_count++;
        complete_run();
    end
    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        repeat (5) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        chk("widths", '0, widths);
        chk("miso enable", 1'b0, miso_oe);
        for (int i = 0; i < 7; i++) chk_reg(adr[i], (i == 6) ? 8'h11 : 8'h00);
        for (int i = 0; i < 6; i++) frame({rpwf_pkg::CMD_WR_REG, adr[i]}, 1, wv[i]);
        for (int i = 0; i < 6; i++) chk_reg(adr[i], (i == 2) ? 8'h25 : wv[i]);
        chk_reg(5'h00, 8'h00);
        chk("widths", {6'h00, 6'h1f, 6'h25, 6'h20, 6'h01}, widths);
        chk("varlen", 3'h0, varlen);
        sel(3'h0);
        global_vl <= 1'b1;
        sel(3'h0);
        chk("varlen", 3'h5, varlen);
        frame(rpwf_pkg::CMD_WR_TX, 1, 8'h10);
        chk_reg(rpwf_pkg::ADR_QUEUE_STATUS, 8'h01);
        chk("tx head", {8'h10, 6'h01}, {tx_head.data[7:0], tx_head.len});
        frame(rpwf_pkg::CMD_WR_TX, 33, 8'h40);
        frame(rpwf_pkg::CMD_WR_TX, 5, 8'h80);
        frame(rpwf_pkg::CMD_WR_TX, 2, 8'hc0);
        chk_reg(rpwf_pkg::ADR_QUEUE_STATUS, 8'h21);
        chk("status byte", 8'h0f, host.rx_b[0]);
        pop(1'b1);
        chk("tx head", {8'h5f, 6'h20}, {tx_head.data[255:248], tx_head.len});
        frame(rpwf_pkg::CMD_REUSE, 0, 8'h00);
        chk_reg(rpwf_pkg::ADR_QUEUE_STATUS, 8'h41);
        pop(1'b1);
        chk("tx len", 6'h20, tx_head.len);
        for (int j = 0; j < 2; j++) begin
            @(posedge ref_clk);
            ce <= 1'b1;
            repeat (1100) @(posedge ref_clk);
            ce <= 1'b0;
            repeat (10) @(posedge ref_clk);
        end
        chk("resends", 2, resend_n);
        frame(rpwf_pkg::CMD_WR_TX, 1, 8'h01);
        chk_reg(rpwf_pkg::ADR_QUEUE_STATUS, 8'h21);
        frame(rpwf_pkg::CMD_REUSE, 0, 8'h00);
        frame(rpwf_pkg::CMD_FLUSH_TX, 0, 8'h00);
        chk_reg(rpwf_pkg::ADR_QUEUE_STATUS, 8'h11);
        for (int i = 0; i < 4; i++) push(3'(i + 1), 8'h30 + 8'(32 * i));
        chk("ready", 1'b0, rx_ready);
        chk_reg(rpwf_pkg::ADR_QUEUE_STATUS, 8'h12);
        for (int i = 0; i < 3; i++) begin
            frame(rpwf_pkg::CMD_RD_RX, 4, 8'h00);
            chk("rx pipe", {4'h0, 3'(i + 1), 1'b0}, host.rx_b[0]);
            chk("rx first", 8'h30 + 8'(32 * i), host.rx_b[1]);
            chk("rx last", 8'h33 + 8'(32 * i), host.rx_b[4]);
            chk("ready", 1'b1, rx_ready);
        end
        chk_reg(rpwf_pkg::ADR_QUEUE_STATUS, 8'h11);
        frame({rpwf_pkg::CMD_WR_ACK, 3'h1}, 4, 8'h90);
        tx_role <= 1'b0;
        sel(3'h1);
        chk("ack valid", 1'b0, ack_valid);
        for (int i = 0; i < 4; i++) frame({rpwf_pkg::CMD_WR_ACK, ap[i]}, 4, 8'ha0 + 8'(16 * i));
        sel(3'h2);
        chk("ack first", 8'ha0, ack_head.data[7:0]);
        pop(1'b0);
        chk("ack second", 8'hb0, ack_head.data[7:0]);
        pop(1'b0);
        chk("ack valid", 1'b0, ack_valid);
        sel(3'h4);
        chk("ack other", {1'b1, 8'hc0}, {ack_valid, ack_head.data[7:0]});
        complete_run();
    end
endmodule // test_rpwf_top
bind rpwf_top rpwf_top_monitor mon (.REF_CLK(REF_CLK), .RESETN(RESETN),
    .CSN(CSN), .CE(CE), .TRANSMITTER_ROLE(TRANSMITTER_ROLE),
    .GLOBAL_VARIABLE_LENGTH(GLOBAL_VARIABLE_LENGTH),
    .PIPE_AUTO_ACK(PIPE_AUTO_ACK), .PIPE_WIDTHS(PIPE_WIDTHS),
    .PIPE_VARIABLE_LENGTH(PIPE_VARIABLE_LENGTH),
    .TX_HEAD_VALID(TX_HEAD_VALID), .TX_POP(TX_POP), .TX_RESEND(TX_RESEND),
    .RX_PUSH(RX_PUSH), .RX_PUSH_READY(RX_PUSH_READY),
    .ACK_PIPE_SEL(ACK_PIPE_SEL), .ACK_HEAD_VALID(ACK_HEAD_VALID),
    .ACK_POP(ACK_POP));
`default_nettype wire

// ===== rtl/rpwf_pkg.sv
package rpwf_pkg;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned CE_MIN_NS = 10_000;
    localparam int unsigned CE_MIN_CYC =
        (CE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [4:0] ADR_PIPE1_WIDTH = 5'h12;
    localparam logic [4:0] ADR_PIPE2_WIDTH = 5'h13;
    localparam logic [4:0] ADR_PIPE3_WIDTH = 5'h14;
    localparam logic [4:0] ADR_PIPE4_WIDTH = 5'h15;
    localparam logic [4:0] ADR_PIPE5_WIDTH = 5'h16;
    localparam logic [4:0] ADR_QUEUE_STATUS = 5'h17;
    localparam logic [4:0] ADR_VARLEN = 5'h1c;
    localparam logic [5:0] WIDTH_RST = 6'h00;
    localparam logic [2:0] VARLEN_RST = 3'h0;
    localparam int unsigned VL_LO = 3;
    localparam int unsigned VL_HI = 5;
    localparam int unsigned QS_REUSE = 6;
    localparam int unsigned QS_TX_FULL = 5;
    localparam int unsigned QS_TX_EMPTY = 4;
    localparam int unsigned QS_RX_FULL = 1;
    localparam int unsigned QS_RX_EMPTY = 0;

    // ****************************************************************
    // queues and commands
    // ****************************************************************
    localparam logic [1:0] DEPTH = 2'h3;
    localparam logic [5:0] MAX_BYTES = 6'h20;
    localparam logic [2:0] CMD_RD_REG = 3'h0;
    localparam logic [2:0] CMD_WR_REG = 3'h1;
    localparam logic [7:0] CMD_RD_RX = 8'h61;
    localparam logic [7:0] CMD_WR_TX = 8'ha0;
    localparam logic [7:0] CMD_FLUSH_TX = 8'he1;
    localparam logic [7:0] CMD_FLUSH_RX = 8'he2;
    localparam logic [7:0] CMD_REUSE = 8'he3;
    localparam logic [4:0] CMD_WR_ACK = 5'h15;

    typedef struct packed {
        logic [255:0] data;
        logic [5:0] len;
        logic [2:0] pipe;
    } rpwf_entry_t;

    typedef struct packed {
        logic [5:0] p5;
        logic [5:0] p4;
        logic [5:0] p3;
        logic [5:0] p2;
        logic [5:0] p1;
    } rpwf_widths_t;

endpackage

// ===== rtl/rpwf_top.sv
// Operation
// - each pipe width is six bits: zero unused, 1 to 32 bytes; values 33 to 63 are stored as written
// - transmitter role only: chip-enable high 10 us with reuse active resends last payload
// - reuse persists until transmit write or transmit flush
// - reuse flag set by reuse command, cleared by write or flush
// - transmit full and empty flags follow transmit queue occupancy
// - receive full and empty flags follow receive queue occupancy
// - receiver role only: up to three tagged acknowledge payloads
// - same-pipe acknowledge payloads leave first in first out
// - write-only three-entry transmit queue, 1 to 32 bytes
// - read-only three-entry receive queue shared by all pipes
// - bits 3..5 enable variable length with global and auto-ack
// - global variable length enable gates the per-pipe enables
`timescale 1ns/1ns
`default_nettype none
module rpwf_top (
    input wire logic REF_CLK,
    input wire logic RESETN,
    input wire logic CSN,
    input wire logic SCK,
    input wire logic MOSI,
    output logic MISO,
    output logic MISO_OE,
    input wire logic CE,
    input wire logic TRANSMITTER_ROLE,
    input wire logic GLOBAL_VARIABLE_LENGTH,
    input wire logic [2:0] PIPE_AUTO_ACK,
    output rpwf_pkg::rpwf_widths_t PIPE_WIDTHS,
    output logic [2:0] PIPE_VARIABLE_LENGTH,
    output rpwf_pkg::rpwf_entry_t TX_HEAD,
    output logic TX_HEAD_VALID,
    input wire logic TX_POP,
    output logic TX_RESEND,
    input wire logic RX_PUSH,
    input wire rpwf_pkg::rpwf_entry_t RX_PUSH_ENTRY,
    output logic RX_PUSH_READY,
    input wire logic [2:0] ACK_PIPE_SEL,
    output rpwf_pkg::rpwf_entry_t ACK_HEAD,
    output logic ACK_HEAD_VALID,
    input wire logic ACK_POP
);

    localparam logic [1:0] DEPTH = rpwf_pkg::DEPTH;
    localparam logic [5:0] MAX_BYTES = rpwf_pkg::MAX_BYTES;

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [3:0] pin_s1_q;
    logic [3:0] pin_s2_q;
    logic csn_s3_q;
    logic sck_s3_q;
    logic csn_rise;
    logic csn_fall;
    logic sck_rise;
    logic sck_fall;

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            pin_s1_q <= 4'h1;
            pin_s2_q <= 4'h1;
            csn_s3_q <= 1'b1;
            sck_s3_q <= 1'b0;
        end else begin
            pin_s1_q <= {CE, MOSI, SCK, CSN};
            pin_s2_q <= pin_s1_q;
            csn_s3_q <= pin_s2_q[0];
            sck_s3_q <= pin_s2_q[1];
        end
    end

    assign csn_rise = pin_s2_q[0] & ~csn_s3_q;
    assign csn_fall = ~pin_s2_q[0] & csn_s3_q;
    assign sck_rise = ~pin_s2_q[0] & pin_s2_q[1] & ~sck_s3_q;
    assign sck_fall = ~pin_s2_q[0] & ~pin_s2_q[1] & sck_s3_q;

    // ****************************************************************
    // serial byte engine
    // ****************************************************************
    logic [2:0] bit_cnt_q;
    logic [6:0] in_sh_q;
    logic [7:0] out_sh_q;
    logic [7:0] cmd_q;
    logic [5:0] byte_idx_q;
    logic [255:0] buf_q;
    logic byte_done;
    logic [7:0] in_byte;
    logic [7:0] rd_byte;
    logic [7:0] status_byte;
    logic [7:0] queue_status;

    assign byte_done = sck_rise && (bit_cnt_q == 3'h7);
    assign in_byte = {in_sh_q, pin_s2_q[2]};

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            bit_cnt_q <= 3'h0;
            in_sh_q <= 7'h00;
            cmd_q <= 8'hff;
            byte_idx_q <= 6'h00;
        end else if (csn_fall) begin
            bit_cnt_q <= 3'h0;
            byte_idx_q <= 6'h00;
        end else if (sck_rise) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            in_sh_q <= in_byte[6:0];
            if (byte_done) begin
                if (byte_idx_q == 6'h00) begin
                    cmd_q <= in_byte;
                end
                if (byte_idx_q <= MAX_BYTES) begin
                    byte_idx_q <= byte_idx_q + 6'h01;
                end
            end
        end
    end

    // payload bytes collected lowest byte first
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            buf_q <= '0;
        end else if (csn_fall) begin
            buf_q <= '0;
        end else if (byte_done && byte_idx_q != 6'h00
                     && byte_idx_q <= MAX_BYTES) begin
            buf_q[(byte_idx_q - 6'h01) * 8 +: 8] <= in_byte;
        end
    end

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            out_sh_q <= 8'h00;
        end else if (csn_fall) begin
            out_sh_q <= status_byte;
        end else if (sck_fall) begin
            out_sh_q <= (bit_cnt_q == 3'h0) ? rd_byte
                                            : {out_sh_q[6:0], 1'b0};
        end
    end

    assign MISO = out_sh_q[7];
    assign MISO_OE = ~csn_s3_q;

    // ****************************************************************
    // registers
    // ****************************************************************
    rpwf_pkg::rpwf_widths_t widths_q;
    logic [2:0] varlen_q;

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            widths_q <= {5{rpwf_pkg::WIDTH_RST}};
            varlen_q <= rpwf_pkg::VARLEN_RST;
        end else if (byte_done && byte_idx_q == 6'h01
                     && cmd_q[7:5] == rpwf_pkg::CMD_WR_REG) begin
            case (cmd_q[4:0])
                rpwf_pkg::ADR_PIPE1_WIDTH: widths_q.p1 <= in_byte[5:0];
                rpwf_pkg::ADR_PIPE2_WIDTH: widths_q.p2 <= in_byte[5:0];
                rpwf_pkg::ADR_PIPE3_WIDTH: widths_q.p3 <= in_byte[5:0];
                rpwf_pkg::ADR_PIPE4_WIDTH: widths_q.p4 <= in_byte[5:0];
                rpwf_pkg::ADR_PIPE5_WIDTH: widths_q.p5 <= in_byte[5:0];
                rpwf_pkg::ADR_VARLEN:
                    varlen_q <= in_byte[rpwf_pkg::VL_HI:rpwf_pkg::VL_LO];
                default: ;
            endcase
        end
    end

    assign PIPE_WIDTHS = widths_q;
    // per-pipe enable needs global and auto-ack too
    assign PIPE_VARIABLE_LENGTH =
        varlen_q & PIPE_AUTO_ACK & {3{GLOBAL_VARIABLE_LENGTH}};

    // ****************************************************************
    // command completion
    // ****************************************************************
    rpwf_pkg::rpwf_entry_t tx_q [3];
    rpwf_pkg::rpwf_entry_t rx_q [3];
    rpwf_pkg::rpwf_entry_t ack_q [3];
    logic [1:0] tx_cnt_q;
    logic [1:0] rx_cnt_q;
    logic [1:0] ack_cnt_q;
    logic reuse_q;
    logic has_data;
    logic tx_push;
    logic tx_pop;
    logic tx_flush;
    logic rx_push;
    logic rx_pop;
    logic rx_flush;
    logic ack_push;
    logic ack_pop;
    logic [1:0] ack_hit;
    logic ack_found;
    rpwf_pkg::rpwf_entry_t new_entry;

    assign has_data = byte_idx_q > 6'h01;
    assign new_entry = '{data: buf_q,
                         len: (byte_idx_q > MAX_BYTES) ? MAX_BYTES
                                                       : byte_idx_q - 6'h01,
                         pipe: cmd_q[2:0]};
    assign tx_flush = csn_rise && cmd_q == rpwf_pkg::CMD_FLUSH_TX;
    assign rx_flush = csn_rise && cmd_q == rpwf_pkg::CMD_FLUSH_RX;
    assign tx_push = csn_rise && cmd_q == rpwf_pkg::CMD_WR_TX
                     && has_data && tx_cnt_q != DEPTH;
    assign ack_push = csn_rise && cmd_q[7:3] == rpwf_pkg::CMD_WR_ACK
                      && has_data && !TRANSMITTER_ROLE
                      && ack_cnt_q != DEPTH;
    assign rx_pop = csn_rise && cmd_q == rpwf_pkg::CMD_RD_RX
                    && has_data && rx_cnt_q != 2'h0;
    // the repeated payload stays at the head while reuse holds
    assign tx_pop = TX_POP && !reuse_q && tx_cnt_q != 2'h0;
    assign rx_push = RX_PUSH && rx_cnt_q != DEPTH;
    assign RX_PUSH_READY = rx_cnt_q != DEPTH;

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            reuse_q <= 1'b0;
        end else if (csn_rise && cmd_q == rpwf_pkg::CMD_REUSE) begin
            reuse_q <= 1'b1;
        end else if (csn_rise && (cmd_q == rpwf_pkg::CMD_WR_TX
                                  || cmd_q == rpwf_pkg::CMD_FLUSH_TX)) begin
            reuse_q <= 1'b0;
        end
    end

    // ****************************************************************
    // transmit queue
    // ****************************************************************
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            tx_cnt_q <= 2'h0;
            for (int i = 0; i < 3; i++) tx_q[i] <= '0;
        end else if (tx_flush) begin
            tx_cnt_q <= 2'h0;
        end else if (tx_pop) begin
            for (int i = 0; i < 2; i++) tx_q[i] <= tx_q[i + 1];
            if (tx_push) begin
                tx_q[tx_cnt_q - 2'h1] <= new_entry;
            end else begin
                tx_cnt_q <= tx_cnt_q - 2'h1;
            end
        end else if (tx_push) begin
            tx_q[tx_cnt_q] <= new_entry;
            tx_cnt_q <= tx_cnt_q + 2'h1;
        end
    end

    assign TX_HEAD = tx_q[0];
    assign TX_HEAD_VALID = tx_cnt_q != 2'h0;

    // ****************************************************************
    // receive queue
    // ****************************************************************
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rx_cnt_q <= 2'h0;
            for (int i = 0; i < 3; i++) rx_q[i] <= '0;
        end else if (rx_flush) begin
            rx_cnt_q <= 2'h0;
        end else if (rx_pop) begin
            for (int i = 0; i < 2; i++) rx_q[i] <= rx_q[i + 1];
            if (rx_push) begin
                rx_q[rx_cnt_q - 2'h1] <= RX_PUSH_ENTRY;
            end else begin
                rx_cnt_q <= rx_cnt_q - 2'h1;
            end
        end else if (rx_push) begin
            rx_q[rx_cnt_q] <= RX_PUSH_ENTRY;
            rx_cnt_q <= rx_cnt_q + 2'h1;
        end
    end

    // ****************************************************************
    // acknowledge queue
    // ****************************************************************
    // slots kept in write order, so the lowest match is the oldest
    always_comb begin
        ack_hit = 2'h0;
        ack_found = 1'b0;
        for (int i = 2; i >= 0; i--) begin
            if (i < ack_cnt_q && ack_q[i].pipe == ACK_PIPE_SEL) begin
                ack_hit = i[1:0];
                ack_found = 1'b1;
            end
        end
    end

    assign ack_pop = ACK_POP && ack_found;

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            ack_cnt_q <= 2'h0;
            for (int i = 0; i < 3; i++) ack_q[i] <= '0;
        end else if (ack_pop) begin
            for (int i = 0; i < 2; i++) begin
                if (i >= ack_hit) ack_q[i] <= ack_q[i + 1];
            end
            if (ack_push) begin
                ack_q[ack_cnt_q - 2'h1] <= new_entry;
            end else begin
                ack_cnt_q <= ack_cnt_q - 2'h1;
            end
        end else if (ack_push) begin
            ack_q[ack_cnt_q] <= new_entry;
            ack_cnt_q <= ack_cnt_q + 2'h1;
        end
    end

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            ACK_HEAD <= '0;
            ACK_HEAD_VALID <= 1'b0;
        end else begin
            ACK_HEAD <= ack_q[ack_hit];
            ACK_HEAD_VALID <= ack_found && !ack_pop;
        end
    end

    // ****************************************************************
    // chip-enable resend
    // ****************************************************************
    logic [9:0] ce_cnt_q;
    localparam logic [9:0] CE_LAST = 10'(rpwf_pkg::CE_MIN_CYC - 1);
    // count parks here so a long pulse resends only once
    localparam logic [9:0] CE_DONE = 10'(rpwf_pkg::CE_MIN_CYC);

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            ce_cnt_q <= 10'h000;
            TX_RESEND <= 1'b0;
        end else begin
            TX_RESEND <= 1'b0;
            if (!pin_s2_q[3]) begin
                ce_cnt_q <= 10'h000;
            end else if (ce_cnt_q == CE_LAST) begin
                ce_cnt_q <= ce_cnt_q + 10'h001;
                TX_RESEND <= TRANSMITTER_ROLE && reuse_q
                             && tx_cnt_q != 2'h0;
            end else if (ce_cnt_q != CE_DONE) begin
                ce_cnt_q <= ce_cnt_q + 10'h001;
            end
        end
    end

    // ****************************************************************
    // read data
    // ****************************************************************
    assign queue_status = {1'b0, reuse_q,
                           tx_cnt_q == DEPTH, tx_cnt_q == 2'h0,
                           2'b00,
                           rx_cnt_q == DEPTH, rx_cnt_q == 2'h0};
    assign status_byte = {4'h0, (rx_cnt_q == 2'h0) ? 3'h7 : rx_q[0].pipe,
                          tx_cnt_q == DEPTH};

    always_comb begin
        rd_byte = 8'h00;
        if (cmd_q == rpwf_pkg::CMD_RD_RX && byte_idx_q != 6'h00
            && byte_idx_q <= MAX_BYTES) begin
            rd_byte = rx_q[0].data[(byte_idx_q - 6'h01) * 8 +: 8];
        end else if (cmd_q[7:5] == rpwf_pkg::CMD_RD_REG
                     && byte_idx_q == 6'h01) begin
            case (cmd_q[4:0])
                rpwf_pkg::ADR_PIPE1_WIDTH: rd_byte = {2'b00, widths_q.p1};
                rpwf_pkg::ADR_PIPE2_WIDTH: rd_byte = {2'b00, widths_q.p2};
                rpwf_pkg::ADR_PIPE3_WIDTH: rd_byte = {2'b00, widths_q.p3};
                rpwf_pkg::ADR_PIPE4_WIDTH: rd_byte = {2'b00, widths_q.p4};
                rpwf_pkg::ADR_PIPE5_WIDTH: rd_byte = {2'b00, widths_q.p5};
                rpwf_pkg::ADR_QUEUE_STATUS: rd_byte = queue_status;
                rpwf_pkg::ADR_VARLEN: rd_byte = {2'b00, varlen_q, 3'b000};
                default: rd_byte = 8'h00;
            endcase
        end
    end

endmodule // rpwf_top
`default_nettype wire
